// File: msdl_link.v
// Purpose: Addressed asynchronous serial link for a multi-drop line
// Assumes: Format straps and station number are static pins
// Notes:   One character buffer each way; APB slave answers in 2 cycles
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "msdl_defines.vh"

// Overview of operation
// RULE_01 - Characters are async, full duplex, one start bit, ASCII coded.
// RULE_02 - Data length strap off gives eight data bits, on gives seven.
// RULE_03 - Parity strap off adds and checks a parity bit, on omits it.
// RULE_04 - With parity in use, sense strap off is even, on is odd.
// RULE_05 - Stop strap off sends two stop bits, on sends one.
// RULE_06 - Rate straps give 9600, 19200, 38400, and 9600 for both on.
// RULE_07 - The unit holds a station number from 00 to 15.
// RULE_08 - The host addresses at most sixteen units on one line.
// RULE_09 - Each unit on a line must carry a unique station number.
// RULE_10 - Power must be cycled after a strap change before use.
// RULE_11 - Control codes are ACK 06h, NAK 15h, STX 02h and ETX 03h.
// RULE_12 - A block check byte is even column parity after STX up to ETX.
// RULE_13 - Parity failure or low first stop bit flags an error, drops frame.
// RULE_14 - Format and rate straps are taken at reset and then ignored.
module msdl_link #(
   parameter DATA_W = 32
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              reset,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [DATA_W-1:0] pwdata,
   output reg  [DATA_W-1:0] prdata,
   output reg               pready,
   output reg               pslverr,
   // Format and station straps
   input  wire              data7_sel,
   input  wire              no_parity_sel,
   input  wire              odd_parity_sel,
   input  wire              one_stop_sel,
   input  wire              rate_select_high,
   input  wire              rate_select_low,
   input  wire [3:0]        station_number,
   // Line side
   input  wire              rxd,
   output reg               txd,
   output reg               txd_oe_n,
   // Interrupt
   output reg               irq
);
   localparam [1:0] R_IDLE  = 2'h0;
   localparam [1:0] R_START = 2'h1;
   localparam [1:0] R_DATA  = 2'h2;
   localparam [1:0] R_DONE  = 2'h3;
   localparam [1:0] M_IDLE  = 2'h0;
   localparam [1:0] M_BODY  = 2'h1;
   localparam [1:0] M_BCC   = 2'h2;
   // Strap synchronisers and one-time capture
   reg  [9:0]  strap_s1_q;
   reg  [9:0]  strap_s2_q;
   reg  [1:0]  cfg_wait_q;
   reg  [9:0]  cfg_q;
   reg         rxd_s1_q;
   reg         rxd_s2_q;
   reg         rxd_prev_q;
   // Software registers
   reg  [1:0]  ctrl_q;
   reg  [5:0]  int_en_q;
   reg  [5:0]  status_q;
   reg  [7:0]  rx_data_q;
   // Receiver
   reg  [1:0]  r_state_q;
   reg  [11:0] r_tmr_q;
   reg  [3:0]  r_idx_q;
   reg  [9:0]  r_bits_q;
   // Message tracker
   reg  [1:0]  m_state_q;
   reg  [7:0]  m_bcc_q;
   reg  [1:0]  m_idx_q;
   reg  [7:0]  m_ch1_q;
   reg  [7:0]  m_ch0_q;
   // Transmitter
   reg         tx_busy_q;
   reg  [11:0] tx_tmr_q;
   reg  [3:0]  tx_nb_q;
   reg  [10:0] tx_sr_q;
   reg  [7:0]  tx_bcc_q;
   reg         tx_in_msg_q;
   wire cfg_ok    = (cfg_wait_q == 2'h3);
   wire c_data7   = cfg_q[0];
   wire c_nopar   = cfg_q[1];
   wire c_odd     = cfg_q[2];
   wire c_onestop = cfg_q[3];
   wire [1:0] c_rate = cfg_q[5:4];
   wire [3:0] c_station = cfg_q[9:6];
   wire rx_en = ctrl_q[`MSDL_CTRL_RX_EN] & cfg_ok;
   wire tx_en = ctrl_q[`MSDL_CTRL_TX_EN] & cfg_ok;
   // Bit period from the rate straps; both on falls back to the slow rate
   reg  [11:0] period;
   always @* begin
      case (c_rate) // RULE_06
         2'b01:   period = `MSDL_PER_19200;
         2'b10:   period = `MSDL_PER_38400;
         default: period = `MSDL_PER_9600;
      endcase
   end
   // Frame geometry
   wire [3:0] dlen    = c_data7 ? 4'h7 : 4'h8; // RULE_02
   wire [3:0] par_n   = c_nopar ? 4'h0 : 4'h1; // RULE_03
   wire [3:0] stop_n  = c_onestop ? 4'h1 : 4'h2; // RULE_05
   wire [3:0] rx_need = dlen + par_n + 4'h1;
   wire [3:0] tx_tot  = 4'h1 + dlen + par_n + stop_n; // RULE_01
   // APB decode
   wire       acc   = psel & penable & ~pready;
   wire       wr_go = psel & penable & pready & pwrite;
   reg        hit;
   reg [31:0] rd_val;
   always @* begin
      hit = 1'b1;
      rd_val = 32'h0;
      if (paddr == `MSDL_REG_CTRL) begin
         rd_val[1:0] = ctrl_q;
      end else if (paddr == `MSDL_REG_STATUS) begin
         rd_val[5:0] = status_q;
         rd_val[`MSDL_ST_BUSY] = tx_busy_q;
      end else if (paddr == `MSDL_REG_INT_EN) begin
         rd_val[5:0] = int_en_q;
      end else if (paddr == `MSDL_REG_RXDATA) begin
         rd_val[7:0] = rx_data_q;
      end else if (paddr == `MSDL_REG_CFG) begin
         rd_val[9:0] = cfg_q;
         rd_val[10] = cfg_ok;
      end else if (paddr == `MSDL_REG_INT_CLR || paddr == `MSDL_REG_TXDATA
                   || paddr == `MSDL_REG_TXBCC) begin
         rd_val = 32'h0;
      end else begin
         hit = 1'b0;
      end
   end
   // Bus answer one cycle into the access phase
   always @(posedge mclk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= {DATA_W{1'b0}};
      end else begin
         pready  <= acc;
         pslverr <= acc & ~hit;
         prdata  <= (acc & ~pwrite & hit) ? rd_val[DATA_W-1:0] : {DATA_W{1'b0}};
      end
   end
   // Software control registers
   always @(posedge mclk) begin
      if (reset) begin
         ctrl_q   <= `MSDL_CTRL_RST;
         int_en_q <= `MSDL_INT_EN_RST;
      end else if (wr_go) begin
         if (paddr == `MSDL_REG_CTRL) begin
            ctrl_q <= pwdata[1:0];
         end else if (paddr == `MSDL_REG_INT_EN) begin
            int_en_q <= pwdata[5:0];
         end
      end
   end
   // Straps pass two flops, then are frozen once; later changes need a reset
   always @(posedge mclk) begin
      if (reset) begin
         strap_s1_q <= 10'h000;
         strap_s2_q <= 10'h000;
         cfg_wait_q <= 2'h0;
         cfg_q      <= 10'h000;
      end else begin
         strap_s1_q <= {station_number, rate_select_high, rate_select_low,
                        one_stop_sel, odd_parity_sel, no_parity_sel, data7_sel};
         strap_s2_q <= strap_s1_q;
         if (cfg_wait_q != 2'h3)
            cfg_wait_q <= cfg_wait_q + 2'h1;
         if (cfg_wait_q == 2'h2)
            cfg_q <= strap_s2_q; // RULE_14 RULE_07
      end
   end
   // Line input synchroniser
   always @(posedge mclk) begin
      if (reset) begin
         rxd_s1_q   <= 1'b1;
         rxd_s2_q   <= 1'b1;
         rxd_prev_q <= 1'b1;
      end else begin
         rxd_s1_q   <= rxd;
         rxd_s2_q   <= rxd_s1_q;
         rxd_prev_q <= rxd_s2_q;
      end
   end
   // Received character decode
   wire [7:0] r_data  = c_data7 ? {1'b0, r_bits_q[6:0]} : r_bits_q[7:0];
   wire       r_parb  = r_bits_q[dlen];
   wire       r_stop  = r_bits_q[dlen + par_n];
   wire       r_perr  = ~c_nopar & ((^r_data) ^ r_parb ^ c_odd); // RULE_03 RULE_04
   wire       r_cerr  = r_perr | ~r_stop; // RULE_13
   wire       r_fin   = (r_state_q == R_DONE);
   wire       r_good  = r_fin & ~r_cerr;
   // Receiver: mid-bit sampling from the start edge
   always @(posedge mclk) begin
      if (reset) begin
         r_state_q <= R_IDLE;
         r_tmr_q   <= 12'h000;
         r_idx_q   <= 4'h0;
         r_bits_q  <= 10'h000;
      end else begin
         case (r_state_q)
            R_IDLE: begin
               if (rx_en & rxd_prev_q & ~rxd_s2_q) begin
                  r_state_q <= R_START;
                  r_tmr_q   <= {1'b0, period[11:1]};
               end
            end
            R_START: begin
               if (r_tmr_q != 12'h000) begin
                  r_tmr_q <= r_tmr_q - 12'h001;
               end else if (~rxd_s2_q) begin // RULE_01
                  r_state_q <= R_DATA;
                  r_tmr_q   <= period - 12'h001;
                  r_idx_q   <= 4'h0;
               end else begin
                  r_state_q <= R_IDLE; // Glitch, not a start bit
               end
            end
            R_DATA: begin
               if (r_tmr_q != 12'h000) begin
                  r_tmr_q <= r_tmr_q - 12'h001;
               end else begin
                  r_bits_q[r_idx_q] <= rxd_s2_q;
                  r_tmr_q <= period - 12'h001;
                  r_idx_q <= r_idx_q + 4'h1;
                  if (r_idx_q == rx_need - 4'h1)
                     r_state_q <= R_DONE;
               end
            end
            default: begin
               r_state_q <= R_IDLE; // Second stop bit unchecked; idle covers it
            end
         endcase
      end
   end
   // Expected station address in ASCII, tens then units
   wire       st_hi  = (c_station >= `MSDL_STATION_TEN);
   wire [3:0] st_lo  = st_hi ? c_station - `MSDL_STATION_TEN : c_station;
   wire [7:0] exp_c1 = st_hi ? `MSDL_ASCII_1 : `MSDL_ASCII_0;
   wire [7:0] exp_c0 = `MSDL_ASCII_0 + {4'h0, st_lo};
   wire       addr_ok = (m_ch1_q == exp_c1) & (m_ch0_q == exp_c0);
   wire       m_end   = r_good & (m_state_q == M_BCC) & (r_data != `MSDL_STX);
   wire       m_ok    = m_end & (r_data == m_bcc_q) & addr_ok; // RULE_12
   // Message tracker; a bad character drops the message in progress
   always @(posedge mclk) begin
      if (reset) begin
         m_state_q <= M_IDLE;
         m_bcc_q   <= 8'h00;
         m_idx_q   <= 2'h0;
         m_ch1_q   <= 8'h00;
         m_ch0_q   <= 8'h00;
      end else if (r_fin & r_cerr) begin
         m_state_q <= M_IDLE; // RULE_13
      end else if (r_good) begin
         if (r_data == `MSDL_STX) begin // RULE_11
            m_state_q <= M_BODY;
            m_bcc_q   <= 8'h00;
            m_idx_q   <= 2'h0;
         end else if (m_state_q == M_BODY) begin
            m_bcc_q <= m_bcc_q ^ r_data; // RULE_12
            if (m_idx_q != 2'h2)
               m_idx_q <= m_idx_q + 2'h1;
            if (m_idx_q == 2'h0)
               m_ch1_q <= r_data;
            if (m_idx_q == 2'h1)
               m_ch0_q <= r_data;
            if (r_data == `MSDL_ETX)
               m_state_q <= M_BCC; // RULE_11
         end else if (m_state_q == M_BCC) begin
            m_state_q <= M_IDLE;
         end
      end
   end
   // Events; a set in the same cycle as a clear wins
   wire [5:0] ev;
   assign ev[`MSDL_EV_RX_RDY]  = r_good;
   assign ev[`MSDL_EV_CHR_ERR] = r_fin & r_cerr; // RULE_13
   assign ev[`MSDL_EV_MSG_OK]  = m_ok;
   assign ev[`MSDL_EV_MSG_BAD] = m_end & ~m_ok;
   assign ev[`MSDL_EV_TX_DONE] = tx_busy_q & (tx_tmr_q == 12'h000) & (tx_nb_q == 4'h0);
   assign ev[`MSDL_EV_OVERRUN] = r_good & status_q[`MSDL_EV_RX_RDY];
   wire [5:0] clr = (wr_go && paddr == `MSDL_REG_INT_CLR) ? pwdata[5:0] : 6'h00;
   wire [5:0] status_d = (status_q & ~clr) | ev;
   // Sticky status, received byte and level interrupt
   always @(posedge mclk) begin
      if (reset) begin
         status_q  <= 6'h00;
         rx_data_q <= 8'h00;
         irq       <= 1'b0;
      end else begin
         status_q <= status_d;
         irq      <= |(status_d & int_en_q);
         if (r_good)
            rx_data_q <= r_data;
      end
   end
   // Transmit frame image, start bit excluded, stop bits held as ones above the data
   wire       tx_bcc_w = wr_go && paddr == `MSDL_REG_TXBCC;
   wire       tx_wr    = wr_go && paddr == `MSDL_REG_TXDATA;
   wire [7:0] tx_byte  = tx_bcc_w ? tx_bcc_q : pwdata[7:0];
   wire       tx_par   = (c_data7 ? ^tx_byte[6:0] : ^tx_byte) ^ c_odd; // RULE_04
   wire       tx_load  = (tx_wr | tx_bcc_w) & tx_en & ~tx_busy_q;
   reg [10:0] tx_img;
   always @* begin
      case ({c_data7, c_nopar}) // RULE_02 RULE_03
         2'b00:   tx_img = {2'b11, tx_par, tx_byte};
         2'b01:   tx_img = {3'b111, tx_byte};
         2'b10:   tx_img = {3'b111, tx_par, tx_byte[6:0]};
         default: tx_img = {4'b1111, tx_byte[6:0]};
      endcase
   end
   // Transmitter; writes while busy are dropped, driver released when idle
   always @(posedge mclk) begin
      if (reset) begin
         tx_busy_q <= 1'b0;
         tx_tmr_q  <= 12'h000;
         tx_nb_q   <= 4'h0;
         tx_sr_q   <= 11'h7ff;
         txd       <= 1'b1;
         txd_oe_n  <= 1'b1;
      end else if (tx_load) begin
         tx_busy_q <= 1'b1;
         tx_tmr_q  <= period - 12'h001;
         tx_nb_q   <= tx_tot - 4'h1;
         tx_sr_q   <= tx_img;
         txd       <= 1'b0; // RULE_01
         txd_oe_n  <= 1'b0;
      end else if (tx_busy_q) begin
         if (tx_tmr_q != 12'h000) begin
            tx_tmr_q <= tx_tmr_q - 12'h001;
         end else if (tx_nb_q != 4'h0) begin
            txd      <= tx_sr_q[0]; // RULE_05
            tx_sr_q  <= {1'b1, tx_sr_q[10:1]};
            tx_nb_q  <= tx_nb_q - 4'h1;
            tx_tmr_q <= period - 12'h001;
         end else begin
            tx_busy_q <= 1'b0;
            txd       <= 1'b1;
            txd_oe_n  <= 1'b1;
         end
      end
   end
   // Running block check over sent bytes after STX through ETX
   always @(posedge mclk) begin
      if (reset) begin
         tx_bcc_q    <= 8'h00;
         tx_in_msg_q <= 1'b0;
      end else if (tx_load & tx_wr) begin
         if (tx_byte == `MSDL_STX) begin // RULE_11
            tx_bcc_q    <= 8'h00;
            tx_in_msg_q <= 1'b1;
         end else if (tx_in_msg_q) begin
            tx_bcc_q <= tx_bcc_q ^ tx_byte; // RULE_12
            if (tx_byte == `MSDL_ETX)
               tx_in_msg_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: msdl_defines.vh
// Purpose: Shared constants for the multi-drop serial link block
// Assumes: 20 MHz mclk, APB with 32-bit data, byte addresses
// Notes:   Included by msdl_link.v and by the bench
`ifndef MSDL_DEFINES_VH
`define MSDL_DEFINES_VH

// Clock and line rates
`define MSDL_CLK_HZ      20000000
`define MSDL_BAUD_9600   9600
`define MSDL_BAUD_19200  19200
`define MSDL_BAUD_38400  38400

// Bit periods in mclk cycles, clock over line rate, truncated
`define MSDL_PER_9600    12'h823
`define MSDL_PER_19200   12'h411
`define MSDL_PER_38400   12'h208

// APB register byte offsets
`define MSDL_REG_CTRL    8'h00
`define MSDL_REG_STATUS  8'h04
`define MSDL_REG_INT_EN  8'h08
`define MSDL_REG_INT_CLR 8'h0c
`define MSDL_REG_TXDATA  8'h10
`define MSDL_REG_RXDATA  8'h14
`define MSDL_REG_CFG     8'h18
`define MSDL_REG_TXBCC   8'h1c

// Reset values
`define MSDL_CTRL_RST    2'h0
`define MSDL_INT_EN_RST  6'h00

// Field positions
`define MSDL_CTRL_RX_EN  0
`define MSDL_CTRL_TX_EN  1
`define MSDL_ST_BUSY     8
`define MSDL_ST_NBITS    6

// Status event bits
`define MSDL_EV_RX_RDY   0
`define MSDL_EV_CHR_ERR  1
`define MSDL_EV_MSG_OK   2
`define MSDL_EV_MSG_BAD  3
`define MSDL_EV_TX_DONE  4
`define MSDL_EV_OVERRUN  5

// Message control characters
`define MSDL_ACK         8'h06
`define MSDL_NAK         8'h15
`define MSDL_STX         8'h02
`define MSDL_ETX         8'h03

// ASCII digits for the station number
`define MSDL_ASCII_0     8'h30
`define MSDL_ASCII_1     8'h31
`define MSDL_STATION_TEN 4'ha

`endif

// File: msdl_link_properties.sv
// Purpose: Port checks for the multi-drop serial link block
// Assumes: One mclk domain, synchronous active high reset
// Notes:   Bound to msdl_link from the bench top file
`timescale 1ns/1ns
`default_nettype none
module msdl_link_properties #(
   parameter DATA_W = 32
) (
   // Clock and reset
   input wire logic              mclk,
   input wire logic              reset,
   // APB slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Line side
   input wire logic              txd,
   input wire logic              txd_oe_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   // Setup cycle followed by the first access cycle
   sequence s_setup;
      psel && !penable ##1 psel && penable;
   endsequence

   property p_ready_lat;
      s_setup |=> pready;
   endproperty
   a_ready_lat: assert property (p_ready_lat) else $error("pready not in second access cycle");

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

   property p_ready_req;
      pready |-> $past(psel) && $past(penable);
   endproperty
   a_ready_req: assert property (p_ready_req) else $error("pready without a request");

   property p_slverr_ready;
      pslverr |-> pready;
   endproperty
   a_slverr_ready: assert property (p_slverr_ready) else $error("pslverr outside answer");

   property p_rdata_idle;
      !pready |-> prdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");

   property p_idle_high;
      txd_oe_n |-> txd;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

   property p_start_len;
      $fell(txd_oe_n) |-> !txd [*8];
   endproperty
   a_start_len: assert property (p_start_len) else $error("start bit missing or short");

   property p_stop_high;
      $rose(txd_oe_n) |-> $past(txd) && $past(txd, 8);
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high at frame end");
endmodule
`default_nettype wire

// File: msdl_host_model.sv
// Purpose: Host side of the serial line, sends and decodes characters
// Assumes: Format and bit period given by the bench, in mclk cycles
// Notes:   Framing faults seen on the unit's characters set ferr
`timescale 1ns/1ns
`default_nettype none
module msdl_host_model (
   // Bit timing clock
   input  wire logic        mclk,
   // Frame format in use
   input  wire logic        d7,
   input  wire logic        np,
   input  wire logic        od,
   input  wire logic        os,
   input  wire logic [11:0] per,
   // Line
   input  wire logic        txd,
   output var  logic        rxd
);
   logic [7:0] got = 8'h00;
   logic       ferr = 1'b0;
   logic [7:0] v;
   int         i;
   initial rxd = 1'b1;

   // One character towards the unit; bad flips the parity bit
   task send(input logic [7:0] c, input logic bad);
      int j;
      rxd <= 1'b0;
      repeat (per) @(posedge mclk);
      for (j = 0; j < (d7 ? 7 : 8); j++) begin
         rxd <= c[j];
         repeat (per) @(posedge mclk);
      end
      if (!np) begin
         rxd <= (d7 ? ^c[6:0] : ^c) ^ od ^ bad;
         repeat (per) @(posedge mclk);
      end
      rxd <= 1'b1;
      repeat (os ? per : 2 * per) @(posedge mclk);
   endtask

   // Decode at mid bit, so a wrong rate or format shows as bad data
   always begin
      @(negedge txd);
      repeat (per / 2) @(posedge mclk);
      if (txd !== 1'b0) ferr = 1'b1;
      v = 8'h00;
      for (i = 0; i < (d7 ? 7 : 8); i++) begin
         repeat (per) @(posedge mclk);
         v[i] = txd;
      end
      if (!np) begin
         repeat (per) @(posedge mclk);
         if (txd !== (^v ^ od)) ferr = 1'b1;
      end
      repeat (per) @(posedge mclk);
      if (txd !== 1'b1) ferr = 1'b1;
      if (!os) begin
         repeat (per) @(posedge mclk);
         if (txd !== 1'b1) ferr = 1'b1;
      end
      got = v;
   end
endmodule
`default_nettype wire

// File: msdl_link_tb.sv
// Purpose: Self-checking bench for the multi-drop serial link block
// Assumes: APB master tasks, host model on the line
// Notes:   Three strap sets, each taken through a reset
`timescale 1ns/1ns
`default_nettype none
`include "msdl_defines.vh"
module msdl_link_tb;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        d7 = 1'b0, np = 1'b0, od = 1'b0, os = 1'b0, rh = 1'b0, rl = 1'b0;
   logic [3:0]  stn = 4'h5;
   logic [5:0]  h_fmt = 6'h00;
   logic [11:0] per = 12'd520;
   logic        rxd, txd, txd_oe_n, irq;
   logic [31:0] rd, cfg_exp;
   logic        err;
   int          fails = 0, samples_checked = 0, k;
   // Straps {data7, nopar, odd, onestop, rate_high, rate_low}
   logic [5:0]  cfg_tab [3] = '{6'b000010, 6'b101111, 6'b010101};
   logic [11:0] per_tab [3] = '{12'd520, 12'd2083, 12'd1041};

   msdl_link dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .data7_sel(d7), .no_parity_sel(np),
      .odd_parity_sel(od), .one_stop_sel(os), .rate_select_high(rh),
      .rate_select_low(rl), .station_number(stn), .rxd(rxd), .txd(txd),
      .txd_oe_n(txd_oe_n), .irq(irq));
   msdl_host_model host (.mclk(mclk), .d7(h_fmt[5]), .np(h_fmt[4]), .od(h_fmt[3]),
      .os(h_fmt[2]), .per(per), .txd(txd), .rxd(rxd));

   // 20 MHz clock
   always #25 mclk = ~mclk;

   task end_sim;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Start a send and poll busy; only the watchdog ends a stuck wait
   task tx_char(input logic [7:0] a, input logic [7:0] c);
      apb(1'b1, a, {24'h0, c});
      do begin
         apb(1'b0, `MSDL_REG_STATUS, 32'h0);
      end while (rd[8] !== 1'b0);
   endtask

   // Framed message from the host with its block check byte; with_tx sends
   // a framed message out meanwhile, full duplex, to keep the run short
   task host_msg(input logic [7:0] hi, input logic [7:0] lo, input logic with_tx);
      apb(1'b1, `MSDL_REG_INT_CLR, 32'h3f);
      fork
         begin
            host.send(`MSDL_STX, 1'b0);
            host.send(hi, 1'b0);
            host.send(lo, 1'b0);
            host.send(`MSDL_ETX, 1'b0);
            host.send(hi ^ lo ^ `MSDL_ETX, 1'b0);
         end
         begin
            if (with_tx) begin
               tx_char(`MSDL_REG_TXDATA, `MSDL_STX);
               tx_char(`MSDL_REG_TXDATA, 8'h41);
               tx_char(`MSDL_REG_TXDATA, `MSDL_ETX);
               tx_char(`MSDL_REG_TXBCC, 8'h00);
            end
         end
      join
      repeat (30) @(posedge mclk);
      apb(1'b0, `MSDL_REG_STATUS, 32'h0);
   endtask

   // Main sequence, one pass per strap set
   initial begin
      for (k = 0; k < 3; k++) begin
         {d7, np, od, os, rh, rl} <= cfg_tab[k];
         h_fmt <= cfg_tab[k];
         per <= per_tab[k];
         reset <= 1'b1;
         repeat (8) @(posedge mclk);
         reset <= 1'b0;
         // Straps are frozen on the third edge after release
         repeat (4) @(posedge mclk);
         cfg_exp = {21'h0, 1'b1, stn, cfg_tab[k][1:0], cfg_tab[k][2], cfg_tab[k][3],
                    cfg_tab[k][4], cfg_tab[k][5]};
         apb(1'b0, `MSDL_REG_CFG, 32'h0);
         chk(rd, cfg_exp);
         apb(1'b0, `MSDL_REG_CTRL, 32'h0);
         chk(rd, 32'h0);
         apb(1'b0, 8'h20, 32'h0);
         chk({31'h0, err}, 32'h1);
         apb(1'b1, `MSDL_REG_CTRL, 32'h3);
         apb(1'b1, `MSDL_REG_INT_EN, (k == 1) ? 32'h2f : 32'h3f);
         {d7, np, od, os, rh, rl} <= ~cfg_tab[k];
         apb(1'b0, `MSDL_REG_CFG, 32'h0);
         chk(rd, cfg_exp);
         fork
            tx_char(`MSDL_REG_TXDATA, 8'hc1);
            begin
               if (k == 2) host.send(8'h33, 1'b0);
            end
         join
         chk({24'h0, host.got}, cfg_tab[k][5] ? 32'h41 : 32'hc1);
         chk({31'h0, host.ferr}, 32'h0);
         chk({31'h0, irq}, (k == 1) ? 32'h0 : 32'h1);
         apb(1'b1, `MSDL_REG_INT_CLR, 32'h3f);
         repeat (2) @(posedge mclk);
         chk({31'h0, irq}, 32'h0);
         if (k == 0) begin
            host_msg(8'h30, 8'h35, 1'b1);
            chk({24'h0, host.got}, 32'h42);
            chk({30'h0, rd[3:2]}, 32'h1);
            host_msg(8'h30, 8'h36, 1'b0);
            chk({30'h0, rd[3:2]}, 32'h2);
            apb(1'b1, `MSDL_REG_INT_CLR, 32'h3f);
            host.send(8'h41, 1'b1);
            repeat (30) @(posedge mclk);
            apb(1'b0, `MSDL_REG_STATUS, 32'h0);
            chk({31'h0, rd[1]}, 32'h1);
            apb(1'b0, `MSDL_REG_RXDATA, 32'h0);
            chk(rd, 32'h05);
         end
         if (k == 2) begin
            repeat (30) @(posedge mclk);
            apb(1'b0, `MSDL_REG_RXDATA, 32'h0);
            chk(rd, 32'h33);
         end
      end
      end_sim;
   end

   // Watchdog, well past the longest clean run of about 110000 cycles
   initial begin
      repeat (130000) @(posedge mclk);
      fails++;
      end_sim;
   end
endmodule

bind msdl_link msdl_link_properties #(.DATA_W(DATA_W)) u_props (.mclk(mclk), .reset(reset),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .txd(txd), .txd_oe_n(txd_oe_n));
`default_nettype wire
